//--- rrd_debounce.sv
module rrd_debounce
    import rrd_pkg::*;
#(
    parameter int W      = 6,
    parameter int CYCLES = 125000
) (
    // clock and reset
    input  logic         clk_sys,
    input  logic         reset_n,
    // raw pins and filtered levels
    input  logic [W-1:0] pin,
    output logic [W-1:0] level
);

    localparam int CW = $clog2(CYCLES + 1);

    // refuse settings the counters cannot serve
    if (W < 1 || CYCLES < 1) begin : g_bad
        $error("rrd_debounce: width and cycle count must be positive");
    end

    typedef struct packed {
        logic [W-1:0]          s1;
        logic [W-1:0]          s2;
        logic [W-1:0]          level;
        logic [W-1:0][CW-1:0]  cnt;
    } rrd_deb_state_t;

    rrd_deb_state_t q;
    rrd_deb_state_t d;

    // level flips only after CYCLES agreeing samples of the new value
    always_comb begin
        d    = q;
        d.s1 = pin;
        d.s2 = q.s1;   // first stage feeds only the second
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.level[i]) begin
                d.cnt[i] = '0;
            end else if (q.cnt[i] == CW'(CYCLES - 1)) begin
                d.level[i] = q.s2[i];
                d.cnt[i]   = '0;
            end else begin
                d.cnt[i] = q.cnt[i] + CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;

endmodule

//--- rrd_monitor.sv
`include "rrd_params.svh"
module rrd_monitor
    import rrd_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 4
) (
    // clock and reset
    input logic                   clk_sys,
    input logic                   reset_n,
    // bus and keypad
    input rrd_bus_req_t           bus_req,
    input logic [`RRD_DATA_W-1:0] bus_rdata,
    input logic                   key_enter,
    // remote channels and alarms
    input logic [`RRD_NUM_CH-1:0] remote_in,
    input logic [`RRD_RELAYS-1:0] alarm_cond,
    // outputs under watch
    input logic                   first_alarm_relay,
    input logic                   second_alarm_relay,
    input logic                   total_clear,
    input logic                   block_first_sensor,
    input logic                   block_second_sensor
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] quiet_q;
    logic [5:0]  prev_q;
    logic [3:0]  cfg_q;
    // pins must sit still through the filter before a level moves;
    // a recent write or keypress may also move it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            quiet_q <= '0;
            prev_q  <= '0;
            cfg_q   <= '0;
        end else begin
            prev_q <= remote_in;
            cfg_q  <= {cfg_q[2:0], bus_req.wr | key_enter};
            if (remote_in != prev_q)
                quiet_q <= '0;
            else if (quiet_q != '1)
                quiet_q <= quiet_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    relay_one_hold_a:
        assert property (alarm_cond[0] |=> first_alarm_relay)
        else $error("relay one off during alarm");
    relay_two_hold_a:
        assert property (alarm_cond[1] |=> second_alarm_relay)
        else $error("relay two off during alarm");
    relay_one_drop_a:
        assert property ($fell(first_alarm_relay) |-> !$past(alarm_cond[0]))
        else $error("relay one dropped under alarm");
    relay_two_rise_a:
        assert property ($rose(second_alarm_relay) |-> $past(alarm_cond[1]))
        else $error("relay two rose without alarm");
    total_needs_quiet_a:
        assert property (total_clear |->
            quiet_q >= 32'(DEBOUNCE_CYCLES) || cfg_q != 4'h0)
        else $error("total clear without filtered edge");
    block_one_filter_a:
        assert property ($changed(block_first_sensor) |->
            quiet_q >= 32'(DEBOUNCE_CYCLES) || cfg_q != 4'h0)
        else $error("sensor one block moved unfiltered");
    block_two_filter_a:
        assert property ($changed(block_second_sensor) |->
            quiet_q >= 32'(DEBOUNCE_CYCLES) || cfg_q != 4'h0)
        else $error("sensor two block moved unfiltered");
    rdata_idle_a:
        assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
        else $error("read data outside read slot");
endmodule

bind rrd_top rrd_monitor #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_mon (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .bus_req            (bus_req),
    .bus_rdata          (bus_rdata),
    .key_enter          (key_enter),
    .remote_in          (remote_in),
    .alarm_cond         (alarm_cond),
    .first_alarm_relay  (first_alarm_relay),
    .second_alarm_relay (second_alarm_relay),
    .total_clear        (total_clear),
    .block_first_sensor (block_first_sensor),
    .block_second_sensor(block_second_sensor)
);

//--- rrd_params.svh
`ifndef RRD_PARAMS_SVH
`define RRD_PARAMS_SVH

// clock rate and input filtering time
`define RRD_CLK_MHZ        125
`define RRD_DEBOUNCE_US    1000

// channel and bus geometry
`define RRD_NUM_CH         6
`define RRD_FN_W           4
`define RRD_ADDR_W         8
`define RRD_DATA_W         32
`define RRD_RELAYS         2
`define RRD_CNT_W          8

// register byte addresses
`define RRD_REG_FUNC       8'h00
`define RRD_REG_CTRL       8'h04
`define RRD_REG_STATUS     8'h08
`define RRD_REG_CMD        8'h0C
`define RRD_REG_FIRED      8'h10
`define RRD_REG_COUNT      8'h14

// control register fields
`define RRD_CTRL_LATCH_LSB 0
`define RRD_CTRL_INV_LSB   8

// status register fields
`define RRD_STAT_RELAY_LSB 0
`define RRD_STAT_LATCH_LSB 2
`define RRD_STAT_BLOCK_LSB 4
`define RRD_STAT_LEVEL_LSB 8

// command register fields
`define RRD_CMD_CLR1_BIT   0
`define RRD_CMD_CLR2_BIT   1

`endif

//--- rrd_pkg.sv
package rrd_pkg;

`include "rrd_params.svh"

    // function carried by one remote channel, stepped in this order
    typedef enum logic [`RRD_FN_W-1:0] {
        RRD_FN_DISABLED      = 4'h0,
        RRD_FN_CLR_FIRST     = 4'h1,
        RRD_FN_CLR_SECOND    = 4'h2,
        RRD_FN_CLR_BOTH      = 4'h3,
        RRD_FN_CLR_TOTAL     = 4'h4,
        RRD_FN_CLR_FIRST_TOT = 4'h5,
        RRD_FN_CLR_SECOND_TOT= 4'h6,
        RRD_FN_CLEAR_EVERYTHING = 4'h7,
        RRD_FN_BLOCK_FIRST_SENSOR  = 4'h8,
        RRD_FN_BLOCK_SECOND_SENSOR = 4'h9
    } rrd_func_t;

    // register bus request from software
    typedef struct packed {
        logic [`RRD_ADDR_W-1:0] addr;
        logic [`RRD_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } rrd_bus_req_t;

    // what a channel does to relays, total and accumulation
    typedef struct packed {
        logic clr_first;
        logic clr_second;
        logic clr_total;
        logic blk_first;
        logic blk_second;
    } rrd_effect_t;

endpackage

//--- rrd_switch_model.sv
module rrd_switch_model (
    // clock
    input  logic       clk_sys,
    // wanted contact levels, chatter on change
    input  logic [5:0] want,
    input  logic       bounce,
    // contact lines
    output logic [5:0] remote_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] tgt_q = 6'h00;
    logic [5:0] chg_q = 6'h00;
    logic [1:0] n_q   = 2'h0;
    // a chattering contact flips its changed lines in the first and third of three cycles
    always @(posedge clk_sys) begin
        if (want != tgt_q) begin
            tgt_q <= want;
            chg_q <= want ^ tgt_q;
            n_q   <= bounce ? 2'h3 : 2'h0;
        end else if (n_q != 2'h0) begin
            n_q <= n_q - 2'h1;
        end
    end
    // only the contacts drive these lines, the block never does
    assign remote_in = tgt_q ^ (n_q[0] ? chg_q : 6'h00);
endmodule

//--- rrd_tb.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 4;
    // effect per code: clear one, clear two, total, block one, block two
    localparam logic [4:0] EFF [10] = '{5'h00, 5'h10, 5'h08, 5'h18,
        5'h04, 5'h14, 5'h0C, 5'h1C, 5'h02, 5'h01};
    logic                  clk_sys    = 1'b0;
    logic                  reset_n    = 1'b0;
    rrd_pkg::rrd_bus_req_t bus_req    = '0;
    logic [31:0]           bus_rdata;
    logic                  key_enter  = 1'b0;
    logic [2:0]            key_chan   = 3'h0;
    logic [5:0]            want       = 6'h00;
    logic                  bounce     = 1'b0;
    logic [5:0]            remote_in;
    logic [1:0]            alarm_cond = 2'h0;
    logic                  rly1;
    logic                  rly2;
    logic                  tclr;
    logic                  blk1;
    logic                  blk2;
    logic [31:0]           rd_val;
    int                    bad_count   = 0;
    int                    check_count = 0;

    always #4 clk_sys = ~clk_sys;

    rrd_top #(.DEBOUNCE_CYCLES(DEB)) dut (
        .clk_sys            (clk_sys),
        .reset_n            (reset_n),
        .bus_req            (bus_req),
        .bus_rdata          (bus_rdata),
        .key_enter          (key_enter),
        .key_chan           (key_chan),
        .remote_in          (remote_in),
        .alarm_cond         (alarm_cond),
        .first_alarm_relay  (rly1),
        .second_alarm_relay (rly2),
        .total_clear        (tclr),
        .block_first_sensor (blk1),
        .block_second_sensor(blk2)
    );

    rrd_switch_model sw (
        .clk_sys  (clk_sys),
        .want     (want),
        .bounce   (bounce),
        .remote_in(remote_in)
    );

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        rd_val = bus_rdata;
    endtask

    task automatic key_press(input logic [2:0] ch);
        @(posedge clk_sys);
        key_enter <= 1'b1;
        key_chan  <= ch;
        @(posedge clk_sys);
        key_enter <= 1'b0;
    endtask

    // watch a fixed window, counting total clear pulses
    task automatic watch(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            #1;
            n += int'(tclr === 1'b1);
        end
        @(posedge clk_sys);
    endtask

    task automatic t_reset();
        chk("outputs", 32'h0, {27'h0, blk2, blk1, tclr, rly2, rly1});
        rd_reg(8'h00);
        chk("func reset", 32'h0, rd_val);
        rd_reg(8'h18);
        chk("unmapped", 32'h0, rd_val);
        $display("test reset done");
    endtask

    task automatic t_keypad();
        key_press(3'h6);
        rd_reg(8'h00);
        chk("func ignored", 32'h0, rd_val);
        for (int k = 1; k <= 10; k++) begin
            key_press(3'h2);
            rd_reg(8'h00);
            chk("func step", 32'(k % 10) << 8, rd_val);
        end
        $display("test keypad done");
    endtask

    // every code on channel 0, a disabled channel 5 pressed alongside
    task automatic t_codes();
        logic [4:0] e;
        int         n;
        wr_reg(8'h04, 32'h3);
        for (int i = 0; i < 10; i++) begin
            e = EFF[i];
            wr_reg(8'h00, 32'(i));
            alarm_cond <= 2'h3;
            repeat (2) @(posedge clk_sys);
            alarm_cond <= 2'h0;
            repeat (3) @(posedge clk_sys);
            chk("latched", 32'h3, {30'h0, rly2, rly1});
            want <= 6'h21;
            watch(20, n);
            chk("relay one", 32'(!e[4]), 32'(rly1));
            chk("relay two", 32'(!e[3]), 32'(rly2));
            chk("total", 32'(e[2]), 32'(n));
            chk("blocks", 32'(e[1:0]), {30'h0, blk1, blk2});
            want <= 6'h00;
            watch(20, n);
            chk("blocks off", 32'h0, {30'h0, blk1, blk2});
            wr_reg(8'h0C, 32'h3);
            repeat (2) @(posedge clk_sys);
            chk("latch clear", 32'h0, {30'h0, rly2, rly1});
        end
        $display("test codes done");
    endtask

    // mixed functions at once, contacts chattering
    task automatic t_mix();
        int n;
        wr_reg(8'h00, 32'h0004_9080);
        bounce <= 1'b1;
        want   <= 6'h1A;
        watch(24, n);
        chk("mix total", 32'h1, 32'(n));
        chk("mix blocks", 32'h3, {30'h0, blk2, blk1});
        rd_reg(8'h08);
        chk("levels", 32'h1A, {26'h0, rd_val[13:8]});
        @(posedge clk_sys);
        want <= 6'h00;
        watch(24, n);
        chk("mix off", 32'h0, {30'h0, blk2, blk1});
        rd_reg(8'h14);
        chk("clear count", 32'h5, rd_val);
        rd_reg(8'h10);
        chk("fired", 32'h11, rd_val);
        wr_reg(8'h10, 32'h1);
        rd_reg(8'h10);
        chk("fired clear", 32'h10, rd_val);
        // flipping an idle channel's polarity is an edge and fires
        wr_reg(8'h04, 32'h0000_1003);
        watch(4, n);
        chk("invert fire", 32'h1, 32'(n));
        // a mid-run reset returns every setting to its idle value
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd_reg(8'h04);
        chk("ctrl rerun", 32'h0, rd_val);
        rd_reg(8'h00);
        chk("func rerun", 32'h0, rd_val);
        $display("test mix done");
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_keypad();
        t_codes();
        t_mix();
        wrap_up();
    end

    // cut a hang short
    initial begin
        #800000;
        bad_count++;
        wrap_up();
    end
endmodule

//--- rrd_top.sv
// Notes on behaviour
// - six remote channels, inputs only, never driven
// - each channel keeps its own function selection
// - disabled channel affects nothing at any level
// - first relay-clear function clears relay one only
// - second relay-clear function clears relay two only
// - clear-both function clears both relay latches
// - total-only clear, and relay one plus total
// - relay two plus total clear together
// - clear everything: both latches and total
// - first inhibit blocks sensor one while active
// - second inhibit blocks sensor two while active
// - keypad enter steps function, wrapping through disabled
// - latching relay holds until keypad or remote clear
//
// Added by the designer: the address map and strobed register access.
`include "rrd_params.svh"
module rrd_top
    import rrd_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = `RRD_DEBOUNCE_US * `RRD_CLK_MHZ
) (
    // clock and reset
    input  logic                   clk_sys,
    input  logic                   reset_n,
    // register bus
    input  rrd_bus_req_t           bus_req,
    output logic [`RRD_DATA_W-1:0] bus_rdata,
    // keypad confirm on a highlighted channel
    input  logic                   key_enter,
    input  logic [2:0]             key_chan,
    // remote control channels
    input  logic [`RRD_NUM_CH-1:0] remote_in,
    // alarm conditions from the setpoint logic
    input  logic [`RRD_RELAYS-1:0] alarm_cond,
    // relay drives
    output logic                   first_alarm_relay,
    output logic                   second_alarm_relay,
    // totalizer and accumulation controls
    output logic                   total_clear,
    output logic                   block_first_sensor,
    output logic                   block_second_sensor
);

    // refuse a filter time the debouncer cannot count
    if (DEBOUNCE_CYCLES < 1) begin : g_bad
        $error("rrd_top: debounce count must be at least one cycle");
    end

    // refuse a register layout that the data word cannot hold
    if (`RRD_NUM_CH * `RRD_FN_W > `RRD_DATA_W) begin : g_bad_func
        $error("rrd_top: function fields overflow the data word");
    end
    if (`RRD_CTRL_INV_LSB + `RRD_NUM_CH > `RRD_DATA_W) begin : g_bad_inv
        $error("rrd_top: polarity field overflows the data word");
    end
    if (`RRD_STAT_LEVEL_LSB + `RRD_NUM_CH > `RRD_DATA_W) begin : g_bad_lvl
        $error("rrd_top: level field overflows the data word");
    end
    if (`RRD_CNT_W > `RRD_DATA_W) begin : g_bad_cnt
        $error("rrd_top: clear counter is wider than the data word");
    end
    if (`RRD_CMD_CLR2_BIT >= `RRD_DATA_W) begin : g_bad_cmd
        $error("rrd_top: command bit lies outside the data word");
    end

    // overlapping fields would read back one value through another
    localparam bit FIELD_CLASH =
        (`RRD_CTRL_LATCH_LSB + `RRD_RELAYS > `RRD_CTRL_INV_LSB) ||
        (`RRD_STAT_RELAY_LSB + `RRD_RELAYS > `RRD_STAT_LATCH_LSB) ||
        (`RRD_STAT_LATCH_LSB + `RRD_RELAYS > `RRD_STAT_BLOCK_LSB) ||
        (`RRD_STAT_BLOCK_LSB + `RRD_RELAYS > `RRD_STAT_LEVEL_LSB);
    if (FIELD_CLASH) begin : g_bad_clash
        $error("rrd_top: register fields overlap");
    end

    // the channel select and the relay pins are sized by hand
    if (`RRD_NUM_CH > (1 << $bits(key_chan))) begin : g_bad_keys
        $error("rrd_top: channel select cannot reach every channel");
    end
    localparam int RELAY_PINS =
        $bits(first_alarm_relay) + $bits(second_alarm_relay);
    if (`RRD_RELAYS != RELAY_PINS) begin : g_bad_relays
        $error("rrd_top: two relay pins serve exactly two latches");
    end

    // complete state of the decoder
    typedef struct packed {
        rrd_func_t [`RRD_NUM_CH-1:0] func;
        logic [`RRD_RELAYS-1:0]      latch_en;
        logic [`RRD_NUM_CH-1:0]      invert;
        logic [`RRD_NUM_CH-1:0]      prev_act;
        logic [`RRD_RELAYS-1:0]      latch;
        logic                        relay1;
        logic                        relay2;
        logic                        tot_clr;
        logic                        blk1;
        logic                        blk2;
        logic [`RRD_NUM_CH-1:0]      fired;
        logic [`RRD_CNT_W-1:0]       clr_count;
        logic [`RRD_DATA_W-1:0]      rdata;
    } rrd_state_t;

    rrd_state_t                 q;
    rrd_state_t                 d;
    logic [`RRD_NUM_CH-1:0]     level;

    // decode a function into its effects
    function automatic rrd_effect_t fn_effect(input rrd_func_t f);
        rrd_effect_t e;
        e = '0;
        case (f)
            RRD_FN_CLR_FIRST: begin
                e.clr_first = 1'b1;
            end
            RRD_FN_CLR_SECOND: begin
                e.clr_second = 1'b1;
            end
            RRD_FN_CLR_BOTH: begin
                e.clr_first  = 1'b1;
                e.clr_second = 1'b1;
            end
            RRD_FN_CLR_TOTAL: begin
                e.clr_total = 1'b1;
            end
            RRD_FN_CLR_FIRST_TOT: begin
                e.clr_first = 1'b1;
                e.clr_total = 1'b1;
            end
            RRD_FN_CLR_SECOND_TOT: begin
                e.clr_second = 1'b1;
                e.clr_total  = 1'b1;
            end
            RRD_FN_CLEAR_EVERYTHING: begin
                e.clr_first  = 1'b1;
                e.clr_second = 1'b1;
                e.clr_total  = 1'b1;
            end
            RRD_FN_BLOCK_FIRST_SENSOR: begin
                e.blk_first = 1'b1;
            end
            RRD_FN_BLOCK_SECOND_SENSOR: begin
                e.blk_second = 1'b1;
            end
            default: begin
                e = '0;
            end
        endcase
        return e;
    endfunction

    // next function in the keypad cycle
    function automatic rrd_func_t fn_next(input rrd_func_t f);
        rrd_func_t n;
        case (f)
            RRD_FN_BLOCK_SECOND_SENSOR: n = RRD_FN_DISABLED;
            RRD_FN_DISABLED:            n = RRD_FN_CLR_FIRST;
            RRD_FN_CLR_FIRST:           n = RRD_FN_CLR_SECOND;
            RRD_FN_CLR_SECOND:          n = RRD_FN_CLR_BOTH;
            RRD_FN_CLR_BOTH:            n = RRD_FN_CLR_TOTAL;
            RRD_FN_CLR_TOTAL:           n = RRD_FN_CLR_FIRST_TOT;
            RRD_FN_CLR_FIRST_TOT:       n = RRD_FN_CLR_SECOND_TOT;
            RRD_FN_CLR_SECOND_TOT:      n = RRD_FN_CLEAR_EVERYTHING;
            RRD_FN_CLEAR_EVERYTHING:    n = RRD_FN_BLOCK_FIRST_SENSOR;
            RRD_FN_BLOCK_FIRST_SENSOR:  n = RRD_FN_BLOCK_SECOND_SENSOR;
            default:                    n = RRD_FN_DISABLED;
        endcase
        return n;
    endfunction

    // true when a code names a known function
    function automatic logic fn_legal(input logic [`RRD_FN_W-1:0] c);
        return c <= RRD_FN_BLOCK_SECOND_SENSOR;
    endfunction

    // address match for a write or a read strobe
    function automatic logic bus_hit(
        input logic                   strobe,
        input logic [`RRD_ADDR_W-1:0] addr,
        input logic [`RRD_ADDR_W-1:0] reg_addr
    );
        return strobe && (addr == reg_addr);
    endfunction

    // pins are only sampled, never driven: filtering per channel
    rrd_debounce #(
        .W      (`RRD_NUM_CH),
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_deb (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pin     (remote_in),
        .level   (level)
    );

    // next-state logic for configuration, effects, latches and bus
    always_comb begin
        logic [`RRD_NUM_CH-1:0] act;
        logic [`RRD_NUM_CH-1:0] rise;
        logic [`RRD_NUM_CH-1:0] fire_set;
        logic [`RRD_NUM_CH-1:0] fire_clr;
        rrd_effect_t            e;
        logic                   clr1;
        logic                   clr2;
        logic                   clrt;
        logic                   blk1;
        logic                   blk2;
        logic                   wr_func;
        logic                   wr_cmd;
        logic [`RRD_FN_W-1:0]   code;

        d        = q;
        act      = level ^ q.invert;
        rise     = act & ~q.prev_act;      // keeps act on its rising edge only
        fire_set = '0;
        fire_clr = '0;
        e        = '0;
        clr1     = 1'b0;
        clr2     = 1'b0;
        clrt     = 1'b0;
        blk1     = 1'b0;
        blk2     = 1'b0;
        code     = '0;
        wr_func  = bus_hit(bus_req.wr, bus_req.addr, `RRD_REG_FUNC);
        wr_cmd   = bus_hit(bus_req.wr, bus_req.addr, `RRD_REG_CMD);
        d.prev_act = act;

        // gather effects of all channels; any mix may coexist
        for (int i = 0; i < `RRD_NUM_CH; i++) begin
            e = fn_effect(q.func[i]);
            if (rise[i]) begin
                clr1 = clr1 | e.clr_first;
                clr2 = clr2 | e.clr_second;
                clrt = clrt | e.clr_total;
                if (e.clr_first || e.clr_second || e.clr_total) begin
                    fire_set[i] = 1'b1;
                end
            end
            if (act[i]) begin
                blk1 = blk1 | e.blk_first;
                blk2 = blk2 | e.blk_second;
            end
        end

        // keypad clears arrive as command writes
        if (wr_cmd) begin
            clr1 = clr1 | bus_req.wdata[`RRD_CMD_CLR1_BIT];
            clr2 = clr2 | bus_req.wdata[`RRD_CMD_CLR2_BIT];
        end

        // latches: a standing alarm re-sets the latch over a clear
        d.latch[0] = (q.latch[0] & ~clr1)
                   | (alarm_cond[0] & q.latch_en[0]);
        d.latch[1] = (q.latch[1] & ~clr2)
                   | (alarm_cond[1] & q.latch_en[1]);
        d.relay1   = alarm_cond[0] | d.latch[0];
        d.relay2   = alarm_cond[1] | d.latch[1];

        // total clear is a one-cycle pulse; inhibits follow the level
        d.tot_clr = clrt;
        d.blk1    = blk1;
        d.blk2    = blk2;
        if (clrt) begin
            d.clr_count = q.clr_count + `RRD_CNT_W'(1);
        end

        // keypad confirm steps the highlighted channel
        if (key_enter && (32'(key_chan) < `RRD_NUM_CH)) begin
            d.func[key_chan] = fn_next(q.func[key_chan]);
        end

        // software write of a legal selection wins over a keypad step
        if (wr_func) begin
            for (int i = 0; i < `RRD_NUM_CH; i++) begin
                code = bus_req.wdata[i*`RRD_FN_W +: `RRD_FN_W];
                if (fn_legal(code)) begin
                    d.func[i] = rrd_func_t'(code);
                end
            end
        end

        // control: latch enables and per-channel input polarity
        if (bus_hit(bus_req.wr, bus_req.addr, `RRD_REG_CTRL)) begin
            d.latch_en = bus_req.wdata[`RRD_CTRL_LATCH_LSB +: `RRD_RELAYS];
            d.invert   = bus_req.wdata[`RRD_CTRL_INV_LSB +: `RRD_NUM_CH];
        end

        // fired flags: write one to clear, a new event wins
        if (bus_hit(bus_req.wr, bus_req.addr, `RRD_REG_FIRED)) begin
            fire_clr = bus_req.wdata[`RRD_NUM_CH-1:0];
        end
        d.fired = (q.fired & ~fire_clr) | fire_set;

        // read data stand one cycle only, zero otherwise
        d.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `RRD_REG_FUNC: begin
                    d.rdata[`RRD_NUM_CH*`RRD_FN_W-1:0] = q.func;
                end
                `RRD_REG_CTRL: begin
                    d.rdata[`RRD_CTRL_LATCH_LSB +: `RRD_RELAYS] = q.latch_en;
                    d.rdata[`RRD_CTRL_INV_LSB +: `RRD_NUM_CH]   = q.invert;
                end
                `RRD_REG_STATUS: begin
                    d.rdata[`RRD_STAT_RELAY_LSB +: `RRD_RELAYS] =
                        {q.relay2, q.relay1};
                    d.rdata[`RRD_STAT_LATCH_LSB +: `RRD_RELAYS] = q.latch;
                    d.rdata[`RRD_STAT_BLOCK_LSB +: `RRD_RELAYS] =
                        {q.blk2, q.blk1};
                    d.rdata[`RRD_STAT_LEVEL_LSB +: `RRD_NUM_CH] = q.prev_act;
                end
                `RRD_REG_FIRED: begin
                    d.rdata[`RRD_NUM_CH-1:0] = q.fired;
                end
                `RRD_REG_COUNT: begin
                    d.rdata[`RRD_CNT_W-1:0] = q.clr_count;
                end
                default: begin
                    d.rdata = '0;    // command and unmapped read as zero
                end
            endcase
        end
    end

    // state register; every selection starts disabled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign bus_rdata           = q.rdata;
    assign first_alarm_relay   = q.relay1;
    assign second_alarm_relay  = q.relay2;
    assign total_clear         = q.tot_clr;
    assign block_first_sensor  = q.blk1;
    assign block_second_sensor = q.blk2;

endmodule
